// *** hdl/ucs_regs.sv ***
// Purpose: setup and request registers of the usb charger
// Assumes: one clock mclk at 25 MHz, async active-low reset
// Notes: strap pin is synchronised, sampled once after reset
`timescale 1ns/1ps
// Contract
// - bit4 set suppresses limit undervoltage fault
// - bits 2:0 pick dc threshold, reset 111
// - bits 7:6 pick fault retry delay
// - bits 5:4 pick charge detect mode
// - charge detect preloaded from variant and pin
// - bit2 passes plug supply, reduced variant ignores
// - bits 1:0 advertise source current, reset 01
// - buck held off until configured bit written
// - writing sample bit starts one sampling
// - sample bit self clears after results update
// - completion shown as data ready flag
// - force error pulses recovery, reads zero
// - source reset restarts detection, reads zero
module ucs_regs
  import ucs_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0,
  parameter int RETRY_SCALE = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire ucs_req_s req,
  output logic [7:0] rdata,
  input wire logic charge_mode_pin,
  input wire logic fault_event,
  input wire logic sample_done,
  output logic sample_start,
  output logic buck_enable,
  output logic retry_active,
  output logic data_ready,
  output logic force_error_recovery,
  output logic force_unattached_restart,
  output ucs_cfg_s cfg
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ucs_state_e st;
    logic [2:0] pin_sync;
    logic [2:0] pin_fill;
    logic uv_dis;
    logic [2:0] thr;
    logic [1:0] retry;
    logic [1:0] cd;
    logic tc_dis;
    logic pass;
    logic [1:0] src;
    logic done;
    logic sreq;
    logic sstart;
    logic dready;
    logic ferr;
    logic frst;
    logic [31:0] retry_cnt;
    logic ract;
    logic [7:0] rdata;
    ucs_cfg_s cfg;
  } ucs_regs_s;

  ucs_regs_s s_q;
  ucs_regs_s s_d;

  // retry length for a delay code; scale lets simulation shorten it
  function automatic logic [31:0] retry_cycles(input logic [1:0] code);
    int c;
    unique case (code)
      2'h0: c = RETRY0_CYC;
      2'h1: c = RETRY1_CYC;
      2'h2: c = RETRY2_CYC;
      default: c = RETRY3_CYC;
    endcase
    return 32'(c / RETRY_SCALE);
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr_cl;
    logic wr_rd;
    logic wr_dn;
    logic wr_sr;
    logic wr_tc;
    s_d = s_q;
    wr_cl = req.wr && req.addr == ADDR_CURRENT_LIMIT;
    wr_rd = req.wr && req.addr == ADDR_RETRY_DETECT;
    wr_dn = req.wr && req.addr == ADDR_CONFIG_DONE;
    wr_sr = req.wr && req.addr == ADDR_SAMPLE_REQ;
    wr_tc = req.wr && req.addr == ADDR_TYPEC_REQ;
    // three-stage sampler for the strap pin
    s_d.pin_sync = {s_q.pin_sync[1:0], charge_mode_pin};
    // fill marker: stages hold real pin samples once it is full
    s_d.pin_fill = {s_q.pin_fill[1:0], 1'b1};
    s_d.sstart = 1'b0;
    s_d.ferr = 1'b0;
    s_d.frst = 1'b0;
    unique case (s_q.st)
      ST_BOOT: begin
        // reset zeros in the sampler must not pass for the pin level,
        // so wait for a full sampler whose last two stages agree
        if (s_q.pin_fill[2] && s_q.pin_sync[2] == s_q.pin_sync[1]) begin
          // reduced variant has no auto-cdp strap option
          s_d.cd = (s_q.pin_sync[2] && !REDUCED_VARIANT) ?
                   CD_AUTO_CDP : CD_SDP;
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wr_sr && req.wdata[SREQ_BIT]) begin
          s_d.sreq = 1'b1;
          s_d.sstart = 1'b1;
          s_d.dready = 1'b0;
          s_d.st = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (sample_done) begin
          s_d.sreq = 1'b0;
          s_d.dready = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // writable fields; reserved positions dropped
    if (wr_cl) begin
      s_d.uv_dis = req.wdata[UV_DIS_BIT];
      s_d.thr = req.wdata[THR_LSB +: 3];
    end
    if (wr_rd) begin
      s_d.retry = req.wdata[RETRY_LSB +: 2];
      s_d.cd = req.wdata[CD_LSB +: 2];
      s_d.tc_dis = req.wdata[TC_DIS_BIT];
      s_d.pass = req.wdata[PASS_BIT];
      s_d.src = req.wdata[SRC_LSB +: 2];
    end
    // host may clear it again; buck follows it
    if (wr_dn) begin
      s_d.done = req.wdata[DONE_BIT];
    end
    // request bits only pulse, nothing is stored
    if (wr_tc) begin
      s_d.ferr = req.wdata[FERR_BIT];
      s_d.frst = req.wdata[FRST_BIT];
    end
    // retry timer: restarted by each fault, counts down to zero
    if (fault_event) begin
      s_d.retry_cnt = retry_cycles(s_q.retry);
    end else if (s_q.retry_cnt != 32'h0) begin
      s_d.retry_cnt = s_q.retry_cnt - 32'h1;
    end
    // running flag kept in a flop so the output is registered
    s_d.ract = s_d.retry_cnt != 32'h0;
    // read data, reserved and typec request bits read zero
    s_d.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_CURRENT_LIMIT: begin
          s_d.rdata[UV_DIS_BIT] = s_q.uv_dis;
          s_d.rdata[THR_LSB +: 3] = s_q.thr;
        end
        ADDR_RETRY_DETECT: begin
          s_d.rdata[RETRY_LSB +: 2] = s_q.retry;
          s_d.rdata[CD_LSB +: 2] = s_q.cd;
          s_d.rdata[TC_DIS_BIT] = s_q.tc_dis;
          s_d.rdata[PASS_BIT] = s_q.pass;
          s_d.rdata[SRC_LSB +: 2] = s_q.src;
        end
        ADDR_CONFIG_DONE: s_d.rdata[DONE_BIT] = s_q.done;
        ADDR_SAMPLE_REQ: s_d.rdata[SREQ_BIT] = s_q.sreq;
        default: s_d.rdata = 8'h00; // typec request reads zero
      endcase
    end
    // decoded config outputs
    s_d.cfg.uv_fault_en = !s_d.uv_dis;
    s_d.cfg.dc_current_threshold = s_d.thr;
    s_d.cfg.fault_retry_delay = s_d.retry;
    s_d.cfg.charge_detect_select = s_d.cd;
    s_d.cfg.typec_detect_disable = s_d.tc_dis;
    s_d.cfg.plug_supply_passthru = s_d.pass && !REDUCED_VARIANT;
    s_d.cfg.advertised_source_current = s_d.src;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_BOOT;
      s_q.thr <= RST_THR;
      s_q.uv_dis <= RST_UV_DIS;
      s_q.retry <= RST_RETRY;
      s_q.cd <= CD_SDP;
      s_q.tc_dis <= RST_TC_DIS;
      s_q.pass <= RST_PASS;
      s_q.src <= RST_SRC;
      s_q.cfg.uv_fault_en <= 1'b1;
      s_q.cfg.dc_current_threshold <= RST_THR;
      s_q.cfg.plug_supply_passthru <= RST_PASS && !REDUCED_VARIANT;
      s_q.cfg.advertised_source_current <= RST_SRC;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign rdata = s_q.rdata;
  assign cfg = s_q.cfg;
  assign sample_start = s_q.sstart;
  assign buck_enable = s_q.done;
  assign retry_active = s_q.ract;
  assign data_ready = s_q.dready;
  assign force_error_recovery = s_q.ferr;
  assign force_unattached_restart = s_q.frst;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // register writes land in the decoded outputs one edge later
  a_uv_fault_follow: assert property (
    clk_en && req.wr && req.addr == ADDR_CURRENT_LIMIT |=>
    cfg.uv_fault_en == !$past(req.wdata[UV_DIS_BIT]))
    else $error("uv fault bit");
  a_thr_write: assert property (
    clk_en && req.wr && req.addr == ADDR_CURRENT_LIMIT |=>
    cfg.dc_current_threshold == $past(req.wdata[THR_LSB +: 3]))
    else $error("threshold");
  a_retry_write: assert property (
    clk_en && req.wr && req.addr == ADDR_RETRY_DETECT |=>
    cfg.fault_retry_delay == $past(req.wdata[RETRY_LSB +: 2]))
    else $error("retry code");
  a_cd_write: assert property (
    clk_en && req.wr && req.addr == ADDR_RETRY_DETECT |=>
    cfg.charge_detect_select == $past(req.wdata[CD_LSB +: 2]))
    else $error("charge detect code");
  a_pass_write: assert property (
    clk_en && req.wr && req.addr == ADDR_RETRY_DETECT |=>
    cfg.plug_supply_passthru ==
    ($past(req.wdata[PASS_BIT]) && !REDUCED_VARIANT))
    else $error("pass write");
  a_src_write: assert property (
    clk_en && req.wr && req.addr == ADDR_RETRY_DETECT |=>
    cfg.advertised_source_current == $past(req.wdata[SRC_LSB +: 2]))
    else $error("src cur");
  a_pass_reduced: assert property (
    REDUCED_VARIANT |-> !cfg.plug_supply_passthru)
    else $error("pass variant");
  // strap preload: the agreed pin level picks the mode
  a_strap_preload: assert property (
    clk_en && s_q.st == ST_BOOT && s_q.pin_fill[2] &&
    s_q.pin_sync[2] == s_q.pin_sync[1] &&
    !(req.wr && req.addr == ADDR_RETRY_DETECT) |=>
    cfg.charge_detect_select ==
    (($past(s_q.pin_sync[2]) && !REDUCED_VARIANT) ? CD_AUTO_CDP : CD_SDP))
    else $error("strap preload");
  // retry timer starts on a fault
  a_retry_load: assert property (
    clk_en && fault_event |=> retry_active)
    else $error("retry not started");
  // buck only moves on a write to the configured bit
  a_buck_gate: assert property (
    clk_en && !(req.wr && req.addr == ADDR_CONFIG_DONE) |=>
    $stable(buck_enable))
    else $error("buck moved");
  a_buck_set: assert property (
    clk_en && req.wr && req.addr == ADDR_CONFIG_DONE |=>
    buck_enable == $past(req.wdata[DONE_BIT]))
    else $error("buck write");
  // sampling handshake
  a_sample_start: assert property (
    sample_start |-> s_q.sreq && s_q.st == ST_SAMPLE)
    else $error("sample start");
  a_rdy_clear: assert property (
    clk_en && s_q.st == ST_IDLE && req.wr &&
    req.addr == ADDR_SAMPLE_REQ && req.wdata[SREQ_BIT] |=>
    sample_start && !data_ready)
    else $error("ready not cleared");
  a_sreq_clear: assert property (
    clk_en && s_q.st == ST_SAMPLE && sample_done |=>
    !s_q.sreq && data_ready)
    else $error("sreq clear");
  // request pulses
  a_ferr_pulse: assert property (
    force_error_recovery |=>
    !force_error_recovery || $past(clk_en) == 1'b0 || $past(req.wr))
    else $error("ferr pulse");
  a_tc_no_pulse: assert property (
    clk_en && !(req.wr && req.addr == ADDR_TYPEC_REQ) |=>
    !force_error_recovery && !force_unattached_restart)
    else $error("stray request pulse");
  a_frst_pulse: assert property (
    clk_en && req.wr && req.addr == ADDR_TYPEC_REQ &&
    req.wdata[FRST_BIT] |=> force_unattached_restart)
    else $error("restart pulse");
  a_tc_read_zero: assert property (
    clk_en && req.rd && req.addr == ADDR_TYPEC_REQ |=> rdata == 8'h00)
    else $error("typec req read");
  // outside the retry register no read shows bits 7:5 or 3
  a_rsvd_zero: assert property (
    clk_en && req.rd && req.addr != ADDR_RETRY_DETECT |=>
    rdata[7:5] == 3'h0 && !rdata[TC_DIS_BIT])
    else $error("rsvd");

  c_sample: cover property (sample_start ##[1:20] data_ready);
  c_config: cover property ($rose(buck_enable));
  c_restart: cover property (force_unattached_restart);
  c_retry: cover property ($fell(retry_active));
  c_strap: cover property (cfg.charge_detect_select == CD_AUTO_CDP);
endmodule

// *** inc/ucs_pkg.sv ***
// Purpose: constants and carriers for the charger setup register bank
// Assumes: byte-wide register port, offsets as printed
// Notes: field positions and reset values live here only
package ucs_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CURRENT_LIMIT = 8'h02;
  localparam logic [7:0] ADDR_RETRY_DETECT = 8'h03;
  localparam logic [7:0] ADDR_CONFIG_DONE = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE_REQ = 8'h05;
  localparam logic [7:0] ADDR_TYPEC_REQ = 8'h06;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int UV_DIS_BIT = 4;
  localparam int THR_LSB = 0;
  localparam int RETRY_LSB = 6;
  localparam int CD_LSB = 4;
  localparam int TC_DIS_BIT = 3;
  localparam int PASS_BIT = 2;
  localparam int SRC_LSB = 0;
  localparam int DONE_BIT = 0;
  localparam int SREQ_BIT = 0;
  localparam int FERR_BIT = 1;
  localparam int FRST_BIT = 0;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_UV_DIS = 1'h0;
  localparam logic [2:0] RST_THR = 3'h7;
  localparam logic [1:0] RST_RETRY = 2'h0;
  localparam logic RST_TC_DIS = 1'h0;
  localparam logic RST_PASS = 1'h1;
  localparam logic [1:0] RST_SRC = 2'h1;
  localparam logic [1:0] CD_SDP = 2'h0;
  localparam logic [1:0] CD_AUTO_CDP = 2'h1;
  // ---------------------------------------------------------------
  // timing: retry delays in microseconds, clock 25 MHz
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int RETRY0_US = 2000000;
  localparam int RETRY1_US = 1000000;
  localparam int RETRY2_US = 500000;
  localparam int RETRY3_US = 16000;
  localparam int RETRY0_CYC = RETRY0_US * CLK_MHZ;
  localparam int RETRY1_CYC = RETRY1_US * CLK_MHZ;
  localparam int RETRY2_CYC = RETRY2_US * CLK_MHZ;
  localparam int RETRY3_CYC = RETRY3_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_SAMPLE = 2'b10
  } ucs_state_e;

  // register bus request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ucs_req_s;

  // decoded configuration as seen by the analog blocks
  typedef struct packed {
    logic uv_fault_en;
    logic [2:0] dc_current_threshold;
    logic [1:0] fault_retry_delay;
    logic [1:0] charge_detect_select;
    logic typec_detect_disable;
    logic plug_supply_passthru;
    logic [1:0] advertised_source_current;
  } ucs_cfg_s;
endpackage

// *** tb/ucs_sampler_model.sv ***
// Purpose: far side sampler that answers each sample start
// Assumes: start and done are one-cycle pulses on mclk
// Notes: latency is arbitrary, long enough for the host to poll
`timescale 1ns/1ps
module ucs_sampler_model #(
  parameter int LAT = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sample_start,
  output logic sample_done
);
  int cnt;
  // one run per start; done lasts one cycle, results then valid
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= (cnt == 1);
      if (sample_start) cnt <= LAT;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule

// *** tb/ucs_regs_tb_top.sv ***
// Purpose: self-checking bench for the charger setup registers
// Assumes: strap pin low until the last test, which resets again
// Notes: retry counts scaled down so the timer ends in the run
`timescale 1ns/1ps
module ucs_regs_tb_top;
  import ucs_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fault_event = 1'b0;
  logic clk_en = 1'b1;
  logic strap_pin = 1'b0;
  // divides the retry counts so every code ends inside the run
  localparam int SCALE = 100000;
  ucs_req_s req = '0;
  logic [7:0] rdata;
  logic [7:0] d;
  logic sample_start, sample_done, buck_enable, retry_active;
  logic data_ready, f_err, f_rst;
  ucs_cfg_s cfg;
  int failures = 0;
  int total_checks = 0;

  ucs_regs #(.RETRY_SCALE(SCALE)) ucs_regs_inst (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .rdata(rdata), .charge_mode_pin(strap_pin),
    .fault_event(fault_event),
    .sample_done(sample_done), .sample_start(sample_start),
    .buck_enable(buck_enable), .retry_active(retry_active),
    .data_ready(data_ready), .force_error_recovery(f_err),
    .force_unattached_restart(f_rst), .cfg(cfg)
  );
  ucs_sampler_model ucs_sampler_model_inst (
    .mclk(mclk), .rst_n(rst_n), .sample_start(sample_start),
    .sample_done(sample_done)
  );

  // 25 MHz clock
  initial begin
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // single-bit outputs: buck, ready, pulses, retry flag
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask
  // a write is one strobe cycle; #1 lets the answer edge land
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, v};
    @(posedge mclk) req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '0;
    #1 d = rdata;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_CURRENT_LIMIT); chk("lim", 8'h07, d);
    rd(ADDR_RETRY_DETECT); chk("ret", 8'h05, d);
    rd(ADDR_CONFIG_DONE); chk("cfgd", 8'h00, d);
    chk_bit("buck", 1'b0, buck_enable);
    rd(ADDR_TYPEC_REQ); chk("tcr", 8'h00, d);
    rd(8'h20); chk("unmap", 8'h00, d);
    $display("test reset done");
  endtask
  task automatic t_fields();
    wr(ADDR_CURRENT_LIMIT, 8'hff);
    rd(ADDR_CURRENT_LIMIT); chk("lim", 8'h17, d);
    chk_bit("uv", 1'b0, cfg.uv_fault_en);
    wr(ADDR_RETRY_DETECT, 8'hd6);
    rd(ADDR_RETRY_DETECT); chk("ret", 8'hd6, d);
    chk("src", 8'h02, {6'h00, cfg.advertised_source_current});
    chk("cd", 8'h01, {6'h00, cfg.charge_detect_select});
    wr(ADDR_RETRY_DETECT, 8'h0b);
    rd(ADDR_RETRY_DETECT); chk("ret", 8'h0b, d);
    chk_bit("pass", 1'b0, cfg.plug_supply_passthru);
    $display("test fields done");
  endtask
  // a write while the clock enable is low must not land
  task automatic t_freeze();
    @(posedge mclk) clk_en <= 1'b0;
    wr(ADDR_CURRENT_LIMIT, 8'h00);
    chk("frz_thr", 8'h07, {5'h00, cfg.dc_current_threshold});
    chk_bit("frz_uv", 1'b0, cfg.uv_fault_en);
    @(posedge mclk) clk_en <= 1'b1;
    rd(ADDR_CURRENT_LIMIT); chk("frz_lim", 8'h17, d);
    $display("test freeze done");
  endtask
  task automatic t_config();
    wr(ADDR_CONFIG_DONE, 8'hff);
    chk_bit("buck", 1'b1, buck_enable);
    rd(ADDR_CONFIG_DONE); chk("cfgd", 8'h01, d);
    $display("test config done");
  endtask
  task automatic t_sample();
    int i;
    wr(ADDR_SAMPLE_REQ, 8'h01);
    chk_bit("start", 1'b1, sample_start);
    chk_bit("rdy0", 1'b0, data_ready);
    rd(ADDR_SAMPLE_REQ); chk("sbusy", 8'h01, d);
    // look just after each edge, never in the launching time step
    for (i = 0; i < 20 && data_ready !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk_bit("rdy1", 1'b1, data_ready);
    rd(ADDR_SAMPLE_REQ); chk("sreq", 8'h00, d);
    $display("test sample done");
  endtask
  task automatic t_typec();
    wr(ADDR_TYPEC_REQ, 8'h03);
    chk("pulses", 8'h03, {6'h00, f_err, f_rst});
    rd(ADDR_TYPEC_REQ); chk("tcr", 8'h00, d);
    wr(ADDR_TYPEC_REQ, 8'h00);
    chk("nopulse", 8'h00, {6'h00, f_err, f_rst});
    $display("test typec done");
  endtask
  // n is the scaled delay of the code: flag high n cycles, then low
  task automatic t_retry(input logic [7:0] v, input int n);
    wr(ADDR_RETRY_DETECT, v);
    @(posedge mclk) fault_event <= 1'b1;
    @(posedge mclk) fault_event <= 1'b0;
    repeat (n - 1) @(posedge mclk);
    #1 chk_bit("retry_on", 1'b1, retry_active);
    @(posedge mclk);
    #1 chk_bit("retry_off", 1'b0, retry_active);
    $display("test retry done");
  endtask
  // strap high through a second reset selects auto-cdp
  task automatic t_strap();
    @(posedge mclk) strap_pin <= 1'b1;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(ADDR_RETRY_DETECT); chk("strap", 8'h15, d);
    chk_bit("buck_rst", 1'b0, buck_enable);
    $display("test strap done");
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    t_reset();
    t_fields();
    t_freeze();
    t_config();
    t_sample();
    t_sample();
    t_typec();
    t_retry(8'h00, RETRY0_CYC / SCALE);
    t_retry(8'h40, RETRY1_CYC / SCALE);
    t_retry(8'h80, RETRY2_CYC / SCALE);
    t_retry(8'hc0, RETRY3_CYC / SCALE);
    t_strap();
    test_done();
  end

  // watchdog well past the expected 982 cycles
  initial begin
    #(40 * 6000);
    failures++;
    test_done();
  end
endmodule
